// *** design/reset_mode_lowpower_sequencer.sv ***
/*
 * Reset pulse generator, reset cause recorder, mode-select capture,
 * stop / deepest-stop sequencing with pin latch handshake, and the
 * bit timer of the single-wire debug line.
 * Assumes one 250 MHz core_clk, rst_b as power-on reset, pins
 * resolved outside from out/oe, and same-clock request inputs.
 */
`timescale 1ns/100ps
`include "rst_seq_params.svh"

module reset_mode_lowpower_sequencer
    import rst_seq_pkg::*;
#(
    parameter int N_PINS = 8,
    parameter int RST_PULSE = `RST_PULSE_CYCLES,
    parameter int BIT_CYCLES = `DBG_BIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic debug_mode_select_pin_in,
    output logic debug_mode_select_pin_out,
    output logic debug_mode_select_pin_oe,
    input wire logic lvd_trip,
    input wire logic wdog_trip,
    input wire logic illegal_op,
    input wire logic stop_req,
    input wire logic wake_irq,
    input wire logic rtc_wake,
    input wire dbg_cmd_t dbg_cmd,
    output logic dbg_cmd_err,
    input wire logic dbg_tx_valid,
    input wire logic dbg_tx_bit,
    output logic dbg_tx_busy,
    input wire logic [N_PINS-1:0] periph_en,
    output logic [N_PINS-1:0] periph_pin_sel,
    output logic sys_reset,
    output logic gpio_reset_cfg,
    output logic bdm_active,
    output logic power_down,
    output logic pin_latch_hold,
    output logic periph_clk_en,
    output logic debug_clk_en,
    output logic lvd_reset_en,
    output logic lvd_trip_low
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic rst_pin_meta_reg;
    logic rst_pin_sync_reg;
    logic ms_meta_reg;
    logic ms_sync_reg;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pin_meta_reg <= 1'b1;
            rst_pin_sync_reg <= 1'b1;
            ms_meta_reg <= 1'b1;
            ms_sync_reg <= 1'b1;
        end else begin
            rst_pin_meta_reg <= reset_pin_in;
            rst_pin_sync_reg <= rst_pin_meta_reg;
            ms_meta_reg <= debug_mode_select_pin_in;
            ms_sync_reg <= ms_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register decode and control bits

    logic wr_force;
    logic wr_pmsc2;
    logic wr_dbgctl;
    logic ppd_ack;
    logic deep_en_reg;
    logic debug_mode_enable_reg;
    logic trip_high_reg;
    logic partial_powerdown_flag_reg;
    logic [7:0] cause_reg;

    assign wr_force = reg_req.wr && reg_req.addr == `ADDR_FORCE
        && reg_req.wdata[`FORCE_BIT];
    assign wr_pmsc2 = reg_req.wr && reg_req.addr == `ADDR_PMSC2;
    assign wr_dbgctl = reg_req.wr && reg_req.addr == `ADDR_DBGCTL;
    assign ppd_ack = wr_pmsc2 && reg_req.wdata[`PMSC2_PARTIAL_POWERDOWN_ACK];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    seq_state_t state_reg;
    seq_state_t state_next;
    logic [6:0] pulse_cnt_reg;
    logic [1:0] blank_reg;
    logic sample_mode_reg;
    logic pin_event;
    logic [7:0] run_cause;
    logic run_reset;
    logic deep_wake;
    logic enter_reset;
    logic last_reset_cycle;

    // Our own pulse echoes back through the synchroniser, so blank it
    assign pin_event = !rst_pin_sync_reg && blank_reg == 2'h0;
    assign last_reset_cycle = pulse_cnt_reg == 7'(RST_PULSE - 1);

    always_comb begin
        run_cause = 8'h00;
        run_cause[`CAUSE_PIN] = pin_event;
        run_cause[`CAUSE_WDOG] = wdog_trip;
        run_cause[`CAUSE_ILOP] = illegal_op;
        run_cause[`CAUSE_DBGF] = wr_force;
        run_cause[`CAUSE_LVD] = lvd_trip && lvd_reset_en;
    end

    assign run_reset = run_cause != 8'h00;
    assign deep_wake = !rst_pin_sync_reg || rtc_wake;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                if (last_reset_cycle) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (run_reset) begin
                    state_next = ST_RESET;
                end else if (stop_req && deep_en_reg) begin
                    state_next = ST_DEEP_STOP;
                end else if (stop_req) begin
                    state_next = ST_STOP;
                end
            end
            ST_STOP: begin
                if (lvd_trip && lvd_reset_en) begin
                    state_next = ST_RESET;
                end else if (wake_irq) begin
                    state_next = ST_RUN;
                end else if (dbg_cmd.valid && dbg_cmd.background && debug_mode_enable_reg) begin
                    state_next = ST_RUN;
                end
            end
            ST_DEEP_STOP: begin
                if (deep_wake) begin
                    state_next = ST_RESET;
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
    end

    assign enter_reset = state_next == ST_RESET && state_reg != ST_RESET;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_cnt_reg <= 7'h00;
        end else if (state_next != ST_RESET || enter_reset) begin
            pulse_cnt_reg <= 7'h00;
        end else begin
            pulse_cnt_reg <= pulse_cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            blank_reg <= 2'(`PIN_BLANK_CYCLES);
        end else if (state_reg == ST_RESET) begin
            blank_reg <= 2'(`PIN_BLANK_CYCLES);
        end else if (blank_reg != 2'h0) begin
            blank_reg <= blank_reg - 2'h1;
        end
    end

    // Cause and mode-sample flag
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cause_reg <= `CAUSE_RESET_VAL;
            sample_mode_reg <= 1'b1;
        end else if (enter_reset && state_reg == ST_RUN) begin
            cause_reg <= run_cause;
            sample_mode_reg <= wr_force;
        end else if (enter_reset && state_reg == ST_DEEP_STOP) begin
            cause_reg <= `CAUSE_RESET_VAL;
            sample_mode_reg <= 1'b1;
        end else if (enter_reset) begin
            cause_reg <= 8'h00;
            cause_reg[`CAUSE_LVD] <= 1'b1;
            sample_mode_reg <= 1'b0;
        end
    end

    // Mode chosen on the last reset cycle, held after the pin turns debug
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bdm_active <= 1'b0;
        end else if (state_reg == ST_RESET && last_reset_cycle && sample_mode_reg) begin
            bdm_active <= !ms_sync_reg;
        end else if (state_reg == ST_RESET) begin
            bdm_active <= 1'b0;
        end else if (state_reg == ST_STOP && state_next == ST_RUN && !wake_irq) begin
            bdm_active <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software control bits, all cleared by every reset except lvd_reset_en and lvd_trip_low, which are set

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            deep_en_reg <= 1'b0;
            trip_high_reg <= 1'b0;
            lvd_reset_en <= 1'b1;
            lvd_trip_low <= 1'b1;
        end else if (enter_reset) begin
            deep_en_reg <= 1'b0;
            trip_high_reg <= 1'b0;
            lvd_reset_en <= 1'b1;
            lvd_trip_low <= 1'b1;
        end else if (wr_pmsc2) begin
            deep_en_reg <= reg_req.wdata[`PMSC2_DEEP_EN];
            trip_high_reg <= reg_req.wdata[`PMSC2_TRIP_HIGH];
            lvd_reset_en <= reg_req.wdata[`PMSC2_LVD_RST_EN];
            lvd_trip_low <= !reg_req.wdata[`PMSC2_TRIP_HIGH];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            debug_mode_enable_reg <= 1'b0;
        end else if (enter_reset) begin
            debug_mode_enable_reg <= 1'b0;
        end else if (wr_dbgctl) begin
            debug_mode_enable_reg <= reg_req.wdata[`DBGCTL_DEBUG_MODE_ENABLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Partial power-down flag and pin latches; a new set beats the ack

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            partial_powerdown_flag_reg <= 1'b0;
            pin_latch_hold <= 1'b0;
        end else begin
            if (ppd_ack) begin
                partial_powerdown_flag_reg <= 1'b0;
                pin_latch_hold <= 1'b0;
            end
            if (state_reg == ST_DEEP_STOP && deep_wake) begin
                partial_powerdown_flag_reg <= 1'b1;
            end
            if (state_next == ST_DEEP_STOP) begin
                pin_latch_hold <= 1'b1;
            end
        end
    end

    // Frozen while latched; afterwards an idle peripheral yields to port
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            periph_pin_sel <= '0;
        end else if (!pin_latch_hold || ppd_ack) begin
            periph_pin_sel <= periph_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset outputs, power and clock gating

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_pin_out <= 1'b0;
            reset_pin_oe <= 1'b1;
            sys_reset <= 1'b1;
            gpio_reset_cfg <= 1'b1;
            power_down <= 1'b0;
            periph_clk_en <= 1'b0;
            debug_clk_en <= 1'b0;
        end else begin
            reset_pin_out <= 1'b0;
            reset_pin_oe <= state_next == ST_RESET;
            sys_reset <= state_next == ST_RESET;
            gpio_reset_cfg <= state_next == ST_RESET;
            power_down <= state_next == ST_DEEP_STOP;
            periph_clk_en <= state_next == ST_RUN;
            debug_clk_en <= state_next == ST_RUN
                || (state_next == ST_STOP && debug_mode_enable_reg);
        end
    end

    // Memory commands with status answer an error while stopped
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dbg_cmd_err <= 1'b0;
        end else begin
            dbg_cmd_err <= dbg_cmd.valid && dbg_cmd.status_mem
                && (state_reg == ST_STOP || state_reg == ST_DEEP_STOP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debug line bit timer

    logic [4:0] bit_cnt_reg;
    logic bit_val_reg;
    logic [4:0] edge_at;

    assign edge_at = bit_val_reg ? 5'(`DBG_START_CYCLES) : 5'(`DBG_ZERO_CYCLES);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dbg_tx_busy <= 1'b0;
            bit_cnt_reg <= 5'h00;
            bit_val_reg <= 1'b0;
        end else if (state_reg == ST_RESET) begin
            dbg_tx_busy <= 1'b0;
            bit_cnt_reg <= 5'h00;
        end else if (!dbg_tx_busy && dbg_tx_valid && debug_clk_en) begin
            dbg_tx_busy <= 1'b1;
            bit_cnt_reg <= 5'h00;
            bit_val_reg <= dbg_tx_bit;
        end else if (dbg_tx_busy && bit_cnt_reg == 5'(BIT_CYCLES - 1)) begin
            dbg_tx_busy <= 1'b0;
        end else if (dbg_tx_busy) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    // Low phase, one-cycle driven-high speedup, then released
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            debug_mode_select_pin_out <= 1'b0;
            debug_mode_select_pin_oe <= 1'b0;
        end else if (state_next == ST_RESET || !dbg_tx_busy) begin
            debug_mode_select_pin_out <= 1'b0;
            debug_mode_select_pin_oe <= 1'b0;
        end else begin
            debug_mode_select_pin_out <= bit_cnt_reg == edge_at;
            debug_mode_select_pin_oe <= bit_cnt_reg <= edge_at;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses read zero

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            reg_rdata <= 8'h00;
            case (reg_req.addr)
                `ADDR_CAUSE: begin
                    reg_rdata <= cause_reg;
                end
                `ADDR_PMSC2: begin
                    reg_rdata[`PMSC2_DEEP_EN] <= deep_en_reg;
                    reg_rdata[`PMSC2_PARTIAL_POWERDOWN_FLAG] <= partial_powerdown_flag_reg;
                    reg_rdata[`PMSC2_LVD_RST_EN] <= lvd_reset_en;
                    reg_rdata[`PMSC2_TRIP_HIGH] <= trip_high_reg;
                end
                `ADDR_DBGCTL: begin
                    reg_rdata[`DBGCTL_DEBUG_MODE_ENABLE] <= debug_mode_enable_reg;
                    reg_rdata[`DBGCTL_BDM] <= bdm_active;
                    reg_rdata[`DBGCTL_STOPPED] <= state_reg == ST_STOP;
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : reset_mode_lowpower_sequencer

// *** shared/rst_seq_params.svh ***
/*
 * Offsets, field positions, reset values and cycle counts of the reset and
 * low-power sequencer. Assumes an 8-bit register port.
 */
`ifndef RST_SEQ_PARAMS_SVH
`define RST_SEQ_PARAMS_SVH

`define ADDR_CAUSE 8'h00
`define ADDR_FORCE 8'h01
`define ADDR_PMSC2 8'h02
`define ADDR_DBGCTL 8'h03

`define CAUSE_POR 7
`define CAUSE_PIN 6
`define CAUSE_WDOG 5
`define CAUSE_ILOP 4
`define CAUSE_DBGF 3
`define CAUSE_LVD 1

`define FORCE_BIT 0
`define PMSC2_PARTIAL_POWERDOWN_FLAG 3
`define PMSC2_PARTIAL_POWERDOWN_ACK 2
`define PMSC2_DEEP_EN 0
`define PMSC2_LVD_RST_EN 4
`define PMSC2_TRIP_HIGH 5
`define DBGCTL_DEBUG_MODE_ENABLE 7
`define DBGCTL_BDM 6
`define DBGCTL_STOPPED 0

`define CAUSE_RESET_VAL 8'h80
`define RST_PULSE_CYCLES 66
`define DBG_BIT_CYCLES 16
`define DBG_START_CYCLES 4
`define DBG_ZERO_CYCLES 13
`define PIN_BLANK_CYCLES 3

`endif

// *** shared/rst_seq_pkg.sv ***
/*
 * Types shared by the reset and low-power sequencer.
 * Assumes the parameter header is on the include path.
 */
package rst_seq_pkg;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_RUN,
        ST_STOP,
        ST_DEEP_STOP
    } seq_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic status_mem;
        logic background;
    } dbg_cmd_t;

endpackage : rst_seq_pkg

// *** tb/debug_host_model.sv ***
/*
 * Debug host and external reset circuit at the two sequencer pins.
 * Assumes pull-ups on both lines and hold commands from the bench.
 */
`timescale 1ns/100ps

module debug_host_model (
    input wire logic ms_out,
    input wire logic ms_oe,
    input wire logic rst_out,
    input wire logic rst_oe,
    input wire logic hold_ms_low,
    input wire logic hold_rst_low,
    output logic ms_level,
    output logic rst_level
);
    // Released lines float to the pull-up; either side may pull low
    assign ms_level = (ms_oe ? ms_out : 1'b1) & ~hold_ms_low;
    assign rst_level = (rst_oe ? rst_out : 1'b1) & ~hold_rst_low;
endmodule : debug_host_model

// *** tb/rst_seq_properties.sv ***
/*
 * Port checker of the reset and low-power sequencer.
 * Assumes it is bound into the sequencer and sees only its ports.
 */
`timescale 1ns/100ps
`include "rst_seq_params.svh"

module rst_seq_properties
    import rst_seq_pkg::*;
#(
    parameter int RST_PULSE = `RST_PULSE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire reg_req_t reg_req,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic debug_mode_select_pin_out,
    input wire logic debug_mode_select_pin_oe,
    input wire logic wdog_trip,
    input wire dbg_cmd_t dbg_cmd,
    input wire logic dbg_cmd_err,
    input wire logic dbg_tx_valid,
    input wire logic dbg_tx_busy,
    input wire logic sys_reset,
    input wire logic gpio_reset_cfg,
    input wire logic bdm_active,
    input wire logic power_down,
    input wire logic pin_latch_hold,
    input wire logic periph_clk_en,
    input wire logic debug_clk_en
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    int unsigned hi_cnt;
    wire logic sm_cmd = dbg_cmd.valid && dbg_cmd.status_mem;
    wire logic ack_wr = reg_req.wr && reg_req.addr == `ADDR_PMSC2 && reg_req.wdata[`PMSC2_PARTIAL_POWERDOWN_ACK];

    // Power-on release may add one edge before the count starts
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= sys_reset ? hi_cnt + 1 : 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_len;
        $fell(sys_reset) |-> hi_cnt == RST_PULSE || hi_cnt == RST_PULSE + 1;
    endproperty
    a_len: assert property (p_len) else $error("reset pulse length wrong");
    property p_pin;
        sys_reset |-> reset_pin_oe && !reset_pin_out;
    endproperty
    a_pin: assert property (p_pin) else $error("reset pin not pulled low");
    property p_wdog;
        wdog_trip && !sys_reset && periph_clk_en && !bdm_active |=> sys_reset;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog gave no reset");
    property p_mode;
        $fell(sys_reset) |=> ##1 $stable(bdm_active)[*4];
    endproperty
    a_mode: assert property (p_mode) else $error("mode moved after reset");
    property p_gpio;
        gpio_reset_cfg == sys_reset;
    endproperty
    a_gpio: assert property (p_gpio) else $error("port reset config differs");
    property p_err;
        sm_cmd && !sys_reset && !periph_clk_en && !power_down |=> dbg_cmd_err;
    endproperty
    a_err: assert property (p_err) else $error("no stop error on command");
    property p_bit;
        dbg_tx_valid && !dbg_tx_busy && debug_clk_en && !sys_reset
            |=> dbg_tx_busy[*8] ##1 dbg_tx_busy[*8] ##1 !dbg_tx_busy;
    endproperty
    a_bit: assert property (p_bit) else $error("debug bit time wrong");
    property p_spd;
        debug_mode_select_pin_oe && debug_mode_select_pin_out |=> !debug_mode_select_pin_oe;
    endproperty
    a_spd: assert property (p_spd) else $error("speedup pulse too long");
    property p_latch;
        $rose(power_down) |-> pin_latch_hold && !periph_clk_en;
    endproperty
    a_latch: assert property (p_latch) else $error("deep stop without latch");
    property p_hold;
        pin_latch_hold && !ack_wr |=> pin_latch_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("pin latch opened early");
endmodule : rst_seq_properties

bind reset_mode_lowpower_sequencer rst_seq_properties #(.RST_PULSE(RST_PULSE)) u_props (
    .core_clk, .rst_b, .reg_req, .reset_pin_out, .reset_pin_oe,
    .debug_mode_select_pin_out, .debug_mode_select_pin_oe, .wdog_trip, .dbg_cmd,
    .dbg_cmd_err, .dbg_tx_valid, .dbg_tx_busy, .sys_reset, .gpio_reset_cfg,
    .bdm_active, .power_down, .pin_latch_hold, .periph_clk_en, .debug_clk_en
);

// *** tb/tb.sv ***
/*
 * Self-checking bench of the reset and low-power sequencer.
 * Assumes the shared package and parameter header are compiled first.
 */
`timescale 1ns/100ps
`include "rst_seq_params.svh"

module tb
    import rst_seq_pkg::*;
;
    localparam int RST = 8;
    typedef struct packed {
        logic [2:0] src;
        logic [7:0] cause;
    } row_t;
    row_t rows [5] = '{'{3'h0, 8'h20}, '{3'h1, 8'h10}, '{3'h2, 8'h08}, '{3'h3, 8'h02},
        '{3'h4, 8'h40}};
    logic core_clk, rst_b = 1'b0, hold_ms = 1'b1, hold_rst = 1'b0, ms_lvl, rst_lvl;
    logic lvd_trip = 1'b0, wdog_trip = 1'b0, illegal_op = 1'b0, stop_req = 1'b0;
    logic rtc_wake = 1'b0, dbg_tx_valid = 1'b0, dbg_tx_bit = 1'b0;
    logic reset_pin_out, reset_pin_oe, ms_out, ms_oe, dbg_cmd_err, dbg_tx_busy;
    logic sys_reset, gpio_reset_cfg, bdm_active, power_down, pin_latch_hold;
    logic periph_clk_en, debug_clk_en, lvd_reset_en, lvd_trip_low;
    logic [7:0] reg_rdata, periph_pin_sel, periph_en = 8'h0F;
    reg_req_t reg_req = '0;
    dbg_cmd_t dbg_cmd = '0;
    int failures = 0, n_checks = 0, k, n, j, lo, sp, bz;

    reset_mode_lowpower_sequencer #(.RST_PULSE(RST)) u_reset_mode_lowpower_sequencer (
        .core_clk, .rst_b, .reg_req, .reg_rdata, .reset_pin_in(rst_lvl), .reset_pin_out,
        .reset_pin_oe, .debug_mode_select_pin_in(ms_lvl), .debug_mode_select_pin_out(ms_out),
        .debug_mode_select_pin_oe(ms_oe), .lvd_trip, .wdog_trip, .illegal_op, .stop_req,
        .wake_irq(1'b0), .rtc_wake, .dbg_cmd, .dbg_cmd_err, .dbg_tx_valid, .dbg_tx_bit,
        .dbg_tx_busy, .periph_en, .periph_pin_sel, .sys_reset, .gpio_reset_cfg, .bdm_active,
        .power_down, .pin_latch_hold, .periph_clk_en, .debug_clk_en, .lvd_reset_en,
        .lvd_trip_low
    );
    debug_host_model u_debug_host_model (
        .ms_out, .ms_oe, .rst_out(reset_pin_out), .rst_oe(reset_pin_oe),
        .hold_ms_low(hold_ms), .hold_rst_low(hold_rst), .ms_level(ms_lvl), .rst_level(rst_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // External circuit lets go once the device pulls the pin itself
    always @(posedge core_clk) begin
        if (sys_reset) begin
            hold_rst <= 1'b0;
        end
    end

    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        reg_req <= '0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask : rd
    task cmd(input dbg_cmd_t c);
        @(posedge core_clk);
        dbg_cmd <= c;
        @(posedge core_clk);
        dbg_cmd <= '0;
        #1;
    endtask : cmd
    task trig(input logic [2:0] s);
        @(posedge core_clk);
        case (s)
            3'h0: wdog_trip <= 1'b1;
            3'h1: illegal_op <= 1'b1;
            3'h2: reg_req <= '{1'b1, 1'b0, `ADDR_FORCE, 8'h01};
            3'h3: lvd_trip <= 1'b1;
            default: hold_rst <= 1'b1;
        endcase
        @(posedge core_clk);
        wdog_trip <= 1'b0;
        illegal_op <= 1'b0;
        lvd_trip <= 1'b0;
        reg_req <= '0;
    endtask : trig
    task rst_wait(output int len);
        len = 0;
        #1;
        for (j = 0; j < 300 && sys_reset !== 1'b1; j++) begin
            @(posedge core_clk);
            #1;
        end
        while (sys_reset === 1'b1 && len < 300) begin
            len++;
            @(posedge core_clk);
            #1;
        end
    endtask : rst_wait
    task conclude;
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        conclude();
    end

    initial begin
        for (k = 0; k < 2; k++) begin
            @(posedge core_clk);
            rst_b <= 1'b0;
            hold_ms <= (k == 0);
            repeat (4) @(posedge core_clk);
            #1;
            chk("reset_pin_oe", 8'h01, 8'(reset_pin_oe));
            chk("gpio_reset_cfg", 8'h01, 8'(gpio_reset_cfg));
            @(posedge core_clk);
            rst_b <= 1'b1;
            rst_wait(n);
            chk("bdm_active", 8'(k == 0), 8'(bdm_active));
            @(posedge core_clk);
            hold_ms <= 1'b0;
        end
        for (k = 0; k < 5; k++) begin
            trig(rows[k].src);
            rst_wait(n);
            chk("reset length", 8'(RST), 8'(n));
            rd(`ADDR_CAUSE, rows[k].cause);
        end
        rd(8'h7E, 8'h00);
        // Light stop with debug enabled
        wr(`ADDR_DBGCTL, 8'h80);
        @(posedge core_clk);
        stop_req <= 1'b1;
        @(posedge core_clk);
        stop_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("periph_clk_en", 8'h00, 8'(periph_clk_en));
        chk("debug_clk_en", 8'h01, 8'(debug_clk_en));
        rd(`ADDR_DBGCTL, 8'h81);
        cmd('{1'b1, 1'b1, 1'b0});
        chk("dbg_cmd_err", 8'h01, 8'(dbg_cmd_err));
        cmd('{1'b1, 1'b0, 1'b1});
        repeat (2) @(posedge core_clk);
        #1;
        chk("bdm_active", 8'h01, 8'(bdm_active));
        for (k = 0; k < 2; k++) begin
            @(posedge core_clk);
            dbg_tx_valid <= 1'b1;
            dbg_tx_bit <= k[0];
            @(posedge core_clk);
            dbg_tx_valid <= 1'b0;
            {lo, sp, bz} = '0;
            repeat (20) begin
                #1;
                lo += int'(ms_oe && !ms_out);
                sp += int'(ms_oe && ms_out);
                bz += int'(dbg_tx_busy);
                @(posedge core_clk);
            end
            chk("bit busy", 8'h10, 8'(bz));
            chk("bit low", k ? 8'h04 : 8'h0D, 8'(lo));
            chk("speedup", 8'h01, 8'(sp));
        end
        // Deep stop woken by the counter, then by the reset pin
        for (k = 0; k < 2; k++) begin
            @(posedge core_clk);
            periph_en <= 8'h0F;
            wr(`ADDR_PMSC2, 8'h01);
            @(posedge core_clk);
            stop_req <= 1'b1;
            @(posedge core_clk);
            stop_req <= 1'b0;
            repeat (2) @(posedge core_clk);
            #1;
            chk("power_down", 8'h01, 8'(power_down));
            chk("pin_latch_hold", 8'h01, 8'(pin_latch_hold));
            chk("periph_clk_en", 8'h00, 8'(periph_clk_en));
            @(posedge core_clk);
            periph_en <= 8'hF0;
            rtc_wake <= (k == 0);
            hold_rst <= (k == 1);
            @(posedge core_clk);
            rtc_wake <= 1'b0;
            rst_wait(n);
            chk("wake reset", 8'(RST), 8'(n));
            chk("periph_pin_sel", 8'h0F, periph_pin_sel);
            chk("lvd_reset_en", 8'h01, 8'(lvd_reset_en));
            chk("lvd_trip_low", 8'h01, 8'(lvd_trip_low));
            rd(`ADDR_CAUSE, 8'h80);
            rd(`ADDR_PMSC2, 8'h18);
            chk("pin_latch_hold", 8'h01, 8'(pin_latch_hold));
            wr(`ADDR_PMSC2, 8'h14);
            repeat (2) @(posedge core_clk);
            #1;
            chk("pin_latch_hold", 8'h00, 8'(pin_latch_hold));
            chk("periph_pin_sel", 8'hF0, periph_pin_sel);
            rd(`ADDR_PMSC2, 8'h10);
        end
        conclude();
    end
endmodule : tb
